// ==== hw/sdc_pkg.sv ====
// Purpose: shared constants and types of the six-channel transfer controller
// Assumes: 16-bit word addresses and data on the internal buses
// Notes:   every offset-free setting reaches the block as a plain port
package sdc_pkg;

  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 16;
  localparam int CHANNELS = 6;
  localparam int CH_W     = 3;

  // sync event codes, everything else is reserved and never fires
  localparam logic [3:0] SYNC_NONE   = 4'h0;
  localparam logic [3:0] SYNC_SP0_RX = 4'h1;
  localparam logic [3:0] SYNC_SP0_TX = 4'h2;
  localparam logic [3:0] SYNC_SP1_RX = 4'h5;
  localparam logic [3:0] SYNC_SP1_TX = 4'h6;
  localparam logic [3:0] SYNC_TIMER0 = 4'hd;
  localparam logic [3:0] SYNC_EXT3   = 4'he;
  localparam logic [3:0] SYNC_TIMER1 = 4'hf;

  // address adjustment after each transfer
  localparam logic [1:0] ADJ_CONST = 2'h0;
  localparam logic [1:0] ADJ_INC   = 2'h1;
  localparam logic [1:0] ADJ_DEC   = 2'h2;
  localparam logic [1:0] ADJ_INDEX = 2'h3;

  // interrupt line select codes
  localparam logic [1:0] ILS_PERIPH  = 2'h0;
  localparam logic [1:0] ILS_CH23    = 2'h1;
  localparam logic [1:0] ILS_CH0123  = 2'h2;
  localparam logic [1:0] ILS_RESET   = 2'h0;

  localparam logic [15:0] ADDR_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0]  FRAME_RESET = 8'h00;

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_READ} sdc_state_t;

  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] elem_count;
    logic [7:0]  frame_count;
    logic [3:0]  sync_event_select;
    logic [1:0]  src_mode;
    logic [1:0]  dst_mode;
    logic        source_index_select;
    logic        destination_index_select;
    logic        dword;
    logic        auto_reinit_enable;
    logic        autobuffering_mode;
    logic        interrupt_enable_bit;
    logic        interrupt_mode_bit;
  } sdc_chan_cfg_t;

  typedef struct packed {
    logic [15:0] global_source_reload;
    logic [15:0] global_destination_reload;
    logic [15:0] global_element_count_reload;
    logic [7:0]  global_frame_count_reload;
  } sdc_reload_t;

  typedef struct packed {
    logic [15:0] element_index_zero;
    logic [15:0] element_index_one;
    logic [15:0] frame_index_zero;
    logic [15:0] frame_index_one;
  } sdc_index_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } sdc_word_t;

endpackage

// ==== hw/sdc_arbiter.sv ====
// Purpose: two-level round-robin channel picker
// Assumes: requests are stable until taken
// Notes:   combinational pick, pointers move only on take
`timescale 1ns/1ps
module sdc_arbiter #(
  parameter int N  = 6,
  parameter int IW = 3
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_reset,
  // requests
  input  wire logic [N-1:0]  i_req,
  input  wire logic [N-1:0]  i_high,
  input  wire logic          i_take,
  // pick
  output logic               o_valid,
  output logic [IW-1:0]      o_index
);

  logic [IW-1:0] last_high;
  logic [IW-1:0] last_low;
  logic [IW:0]   pick_high;
  logic [IW:0]   pick_low;

  // nearest requester after the last winner gets the turn
  function automatic logic [IW:0] rr_pick(input logic [N-1:0] req, input logic [IW-1:0] last);
    logic [IW:0] r;
    int          idx;
    r = '0;
    for (int k = N; k >= 1; k--) begin
      idx = (int'(last) + k) % N;
      if (req[idx]) r = {1'b1, IW'(idx)};
    end
    return r;
  endfunction

  assign pick_high = rr_pick(i_req & i_high, last_high);
  assign pick_low  = rr_pick(i_req & ~i_high, last_low);

  always_comb begin
    o_valid = pick_high[IW] | pick_low[IW];
    o_index = pick_high[IW] ? pick_high[IW-1:0] : pick_low[IW-1:0];
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      last_high <= IW'(N - 1);
      last_low  <= IW'(N - 1);
    end else if (i_take && o_valid) begin
      if (pick_high[IW]) last_high <= o_index;
      else last_low <= o_index;
    end
  end

endmodule

// ==== hw/sdc_buffer.sv ====
// Purpose: two-entry word buffer between the read and write sides
// Assumes: push only when ready, pop only when valid
// Notes:   output word sits in a flop
`timescale 1ns/1ps
module sdc_buffer #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_reset,
  // fill side
  input  wire logic          i_valid,
  input  wire logic [W-1:0]  i_data,
  output logic               o_ready,
  // drain side
  output logic               o_valid,
  output logic [W-1:0]       o_data,
  input  wire logic          i_ready
);

  logic [W-1:0] slot1;
  logic [1:0]   count;
  logic [1:0]   next_count;
  logic         push;
  logic         pop;

  assign push    = i_valid && (count != 2'h2);
  assign pop     = i_ready && (count != 2'h0);
  assign o_ready = count != 2'h2;

  always_comb begin
    next_count = count;
    if (push && !pop) next_count = count + 2'h1;
    else if (pop && !push) next_count = count - 2'h1;
  end

  // valid kept in its own flop so the write request leaves the block registered
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_data  <= '0;
      slot1   <= '0;
      count   <= 2'h0;
      o_valid <= 1'b0;
    end else begin
      count   <= next_count;
      o_valid <= next_count != 2'h0;
      if (push && !pop) begin
        if (count == 2'h0) o_data <= i_data;
        else slot1 <= i_data;
      end else if (pop && !push) begin
        o_data <= slot1;
      end else if (pop && push) begin
        if (count == 2'h1) o_data <= i_data;
        else begin
          o_data <= slot1;
          slot1  <= i_data;
        end
      end
    end
  end

endmodule

// ==== hw/sdc_ctrl.sv ====
// Purpose: six-channel background transfer controller
// Assumes: memory answers reads with i_rd_valid, writes with i_wr_ready
// Notes:   one element in flight; writes drain through a two-entry buffer
`timescale 1ns/1ps
module sdc_ctrl (
  // clock and reset
  input  wire logic                              i_clk,
  input  wire logic                              i_reset,
  // channel setup
  input  wire sdc_pkg::sdc_chan_cfg_t [5:0]      i_cfg,
  input  wire logic [5:0]                        i_chan_enable,
  input  wire logic [5:0]                        i_chan_high,
  input  wire sdc_pkg::sdc_reload_t              i_reload,
  input  wire sdc_pkg::sdc_index_t               i_index,
  input  wire logic [1:0]                        i_interrupt_line_select,
  // event sources
  input  wire logic                              i_port0_rx_event,
  input  wire logic                              i_port0_tx_event,
  input  wire logic                              i_port1_receive_interrupt,
  input  wire logic                              i_port1_transmit_interrupt,
  input  wire logic                              i_timer0_event,
  input  wire logic                              i_second_timer_interrupt,
  input  wire logic                              i_ext3_pin,
  // read port
  output logic                                   o_rd_req,
  output logic [15:0]                            o_rd_addr,
  input  wire logic                              i_rd_valid,
  input  wire logic [15:0]                       i_rd_data,
  // write port
  output logic                                   o_wr_req,
  output logic [15:0]                            o_wr_addr,
  output logic [15:0]                            o_wr_data,
  input  wire logic                              i_wr_ready,
  // status and interrupts
  output logic                                   o_cpu_hold,
  output logic [5:0]                             o_chan_active,
  output logic [5:0]                             o_chan_int,
  output logic                                   o_line6,
  output logic                                   o_line7,
  output logic                                   o_line10,
  output logic                                   o_line11
);

  sdc_pkg::sdc_state_t    st;
  sdc_pkg::sdc_chan_cfg_t cfg_c;
  sdc_pkg::sdc_word_t     buf_in;
  sdc_pkg::sdc_word_t     buf_out;
  logic [2:0]             ch;
  logic                   half;
  logic [15:0]            src       [6];
  logic [15:0]            dst       [6];
  logic [15:0]            elem      [6];
  logic [15:0]            elem_init [6];
  logic [7:0]             frame     [6];
  logic [5:0]             active;
  logic [5:0]             pending;
  logic [5:0]             enable_q;
  logic [5:0]             arb_req;
  logic [5:0]             ie_vec;
  logic [5:0]             int_next;
  logic [1:0]             ils;
  logic [2:0]             ext_ff;
  logic                   ext_stable;
  logic                   ext_edge;
  logic                   arb_valid;
  logic [2:0]             arb_idx;
  logic                   arb_take;
  logic                   buf_ready;
  logic                   buf_out_valid;
  logic                   rd_done;
  logic                   elem_end;
  logic                   frame_last;
  logic                   xfer_last;
  logic                   hold;

  function automatic logic sync_hit(input logic [3:0] sel, input logic [6:0] ev);
    unique case (sel)
      sdc_pkg::SYNC_SP0_RX: return ev[0];
      sdc_pkg::SYNC_SP0_TX: return ev[1];
      sdc_pkg::SYNC_SP1_RX: return ev[2];
      sdc_pkg::SYNC_SP1_TX: return ev[3];
      sdc_pkg::SYNC_TIMER0: return ev[4];
      sdc_pkg::SYNC_EXT3:   return ev[5];
      sdc_pkg::SYNC_TIMER1: return ev[6];
      default:              return 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] adjust(input logic [15:0] a, input logic [1:0] mode, input logic sel,
                                         input logic last, input sdc_pkg::sdc_index_t ix);
    logic [15:0] step;
    step = last ? (sel ? ix.frame_index_one : ix.frame_index_zero)
                : (sel ? ix.element_index_one : ix.element_index_zero);
    unique case (mode)
      sdc_pkg::ADJ_CONST: return a;
      sdc_pkg::ADJ_INC:   return a + 16'h0001;
      sdc_pkg::ADJ_DEC:   return a - 16'h0001;
      sdc_pkg::ADJ_INDEX: return a + step;
    endcase
  endfunction

  sdc_arbiter #(.N(6), .IW(3)) u_arb (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_req   (arb_req),
    .i_high  (i_chan_high),
    .i_take  (arb_take),
    .o_valid (arb_valid),
    .o_index (arb_idx)
  );

  sdc_buffer #(.W(32)) u_buf (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_valid (rd_done),
    .i_data  (buf_in),
    .o_ready (buf_ready),
    .o_valid (buf_out_valid),
    .o_data  (buf_out),
    .i_ready (i_wr_ready)
  );

  // writes go out as soon as a word waits; receiver stall fills the buffer
  assign o_wr_req  = buf_out_valid;
  assign o_wr_addr = buf_out.addr;
  assign o_wr_data = buf_out.data;

  assign cfg_c      = i_cfg[ch];
  assign rd_done    = (st == sdc_pkg::S_READ) && i_rd_valid;
  assign elem_end   = rd_done && (!cfg_c.dword || half);
  assign xfer_last  = (elem[ch] == 16'h0000) && (!cfg_c.dword || half);
  assign frame_last = elem_end && (elem[ch] == 16'h0000);
  assign arb_take   = (st == sdc_pkg::S_IDLE) && arb_valid;
  assign buf_in     = '{addr: dst[ch], data: i_rd_data};

  always_comb begin
    for (int k = 0; k < 6; k++) begin
      arb_req[k] = active[k] && i_chan_enable[k] &&
                   ((i_cfg[k].sync_event_select == sdc_pkg::SYNC_NONE) || pending[k]);
      ie_vec[k]  = i_cfg[k].interrupt_enable_bit;
    end
  end

  // ext3 is a pin: three flops, level counts once the last two agree
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ext_ff     <= 3'h0;
      ext_stable <= 1'b0;
      ext_edge   <= 1'b0;
    end else begin
      ext_ff <= {ext_ff[1:0], i_ext3_pin};
      if (ext_ff[1] == ext_ff[2]) ext_stable <= ext_ff[2];
      ext_edge <= (ext_ff[1] == ext_ff[2]) && ext_ff[2] && !ext_stable;
    end
  end

  // an event in the cycle of the take is kept: set wins
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pending <= 6'h00;
    end else begin
      for (int k = 0; k < 6; k++) begin
        if (sync_hit(i_cfg[k].sync_event_select,
                     {i_second_timer_interrupt, ext_edge, i_timer0_event, i_port1_transmit_interrupt,
                      i_port1_receive_interrupt, i_port0_tx_event, i_port0_rx_event})) pending[k] <= 1'b1;
        else if (arb_take && (arb_idx == 3'(k))) pending[k] <= 1'b0;
      end
    end
  end

  // engine sequencing
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st        <= sdc_pkg::S_IDLE;
      ch        <= 3'h0;
      half      <= 1'b0;
      o_rd_req  <= 1'b0;
      o_rd_addr <= sdc_pkg::ADDR_RESET;
    end else begin
      unique case (st)
        sdc_pkg::S_IDLE: begin
          if (arb_valid) begin
            ch   <= arb_idx;
            half <= 1'b0;
            st   <= sdc_pkg::S_ISSUE;
          end
        end
        sdc_pkg::S_ISSUE: begin
          // read only when the word has a buffer slot waiting
          if (buf_ready) begin
            o_rd_req  <= 1'b1;
            o_rd_addr <= src[ch];
            st        <= sdc_pkg::S_READ;
          end
        end
        sdc_pkg::S_READ: begin
          if (i_rd_valid) begin
            o_rd_req <= 1'b0;
            if (cfg_c.dword && !half) begin
              half <= 1'b1;
              st   <= sdc_pkg::S_ISSUE;
            end else begin
              st <= sdc_pkg::S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // channel context: addresses and counts
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      enable_q <= 6'h00;
      active   <= 6'h00;
      for (int k = 0; k < 6; k++) begin
        src[k]       <= sdc_pkg::ADDR_RESET;
        dst[k]       <= sdc_pkg::ADDR_RESET;
        elem[k]      <= sdc_pkg::COUNT_RESET;
        elem_init[k] <= sdc_pkg::COUNT_RESET;
        frame[k]     <= sdc_pkg::FRAME_RESET;
      end
    end else begin
      enable_q <= i_chan_enable;
      for (int k = 0; k < 6; k++) begin
        if (i_chan_enable[k] && !enable_q[k]) begin
          src[k]       <= i_cfg[k].src;
          dst[k]       <= i_cfg[k].dst;
          elem[k]      <= i_cfg[k].elem_count;
          elem_init[k] <= i_cfg[k].elem_count;
          frame[k]     <= i_cfg[k].frame_count;
          active[k]    <= 1'b1;
        end
      end
      if (rd_done) begin
        src[ch] <= adjust(src[ch], cfg_c.src_mode, cfg_c.source_index_select, xfer_last, i_index);
        dst[ch] <= adjust(dst[ch], cfg_c.dst_mode, cfg_c.destination_index_select, xfer_last, i_index);
        if (elem_end) begin
          if (elem[ch] != 16'h0000) begin
            elem[ch] <= elem[ch] - 16'h0001;
          end else if (cfg_c.autobuffering_mode) begin
            elem[ch] <= elem_init[ch];
          end else if (frame[ch] != 8'h00) begin
            frame[ch] <= frame[ch] - 8'h01;
            elem[ch]  <= elem_init[ch];
          end else if (cfg_c.auto_reinit_enable) begin
            // reload values are taken only here, so software may refill them mid-block
            src[ch]       <= i_reload.global_source_reload;
            dst[ch]       <= i_reload.global_destination_reload;
            elem[ch]      <= i_reload.global_element_count_reload;
            elem_init[ch] <= i_reload.global_element_count_reload;
            frame[ch]     <= i_reload.global_frame_count_reload;
          end else begin
            active[ch] <= 1'b0;
          end
        end
      end
    end
  end

  // per-channel interrupt events
  always_comb begin
    int_next = 6'h00;
    if (elem_end && cfg_c.interrupt_enable_bit) begin
      if (cfg_c.autobuffering_mode) begin
        int_next[ch] = frame_last ||
                       (cfg_c.interrupt_mode_bit && ((elem[ch] - 16'h0001) == {1'b0, elem_init[ch][15:1]}));
      end else begin
        int_next[ch] = (frame_last && (frame[ch] == 8'h00)) || (cfg_c.interrupt_mode_bit && frame_last);
      end
    end
  end

  // shared lines; reserved code drives nothing
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ils           <= sdc_pkg::ILS_RESET;
      o_chan_int    <= 6'h00;
      o_line6       <= 1'b0;
      o_line7       <= 1'b0;
      o_line10      <= 1'b0;
      o_line11      <= 1'b0;
      hold          <= 1'b0;
      o_chan_active <= 6'h00;
    end else begin
      ils           <= i_interrupt_line_select;
      o_chan_int    <= int_next;
      o_chan_active <= active;
      // cpu is held off whenever the engine owns or wants the bus
      hold <= (st != sdc_pkg::S_IDLE) || arb_valid || buf_out_valid;
      unique case (ils)
        sdc_pkg::ILS_PERIPH: begin
          o_line6  <= 1'b0;
          o_line7  <= i_second_timer_interrupt;
          o_line10 <= i_port1_receive_interrupt;
          o_line11 <= i_port1_transmit_interrupt;
        end
        sdc_pkg::ILS_CH23: begin
          o_line6  <= 1'b0;
          o_line7  <= i_second_timer_interrupt;
          o_line10 <= int_next[2];
          o_line11 <= int_next[3];
        end
        sdc_pkg::ILS_CH0123: begin
          o_line6  <= int_next[0];
          o_line7  <= int_next[1];
          o_line10 <= int_next[2];
          o_line11 <= int_next[3];
        end
        default: begin
          o_line6  <= 1'b0;
          o_line7  <= 1'b0;
          o_line10 <= 1'b0;
          o_line11 <= 1'b0;
        end
      endcase
    end
  end

  assign o_cpu_hold = hold;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence first_half_s;
    rd_done && cfg_c.dword && !half;
  endsequence

  cpu_hold_a: assert property (o_rd_req |-> o_cpu_hold)
    else $error("read issued without cpu hold");
  rd_stable_a: assert property (o_rd_req && !i_rd_valid |=> o_rd_req && $stable(o_rd_addr))
    else $error("read request dropped before answer");
  grant_active_a: assert property (arb_take |-> active[arb_idx] && i_chan_enable[arb_idx])
    else $error("finished channel granted");
  sync_gate_a: assert property (arb_take && (i_cfg[arb_idx].sync_event_select != sdc_pkg::SYNC_NONE)
                                |-> pending[arb_idx])
    else $error("synced channel granted without event");
  elem_dec_a: assert property (elem_end && (elem[ch] != 16'h0000) && !(i_chan_enable[ch] && !enable_q[ch])
                               |=> elem[$past(ch)] == $past(elem[ch]) - 16'h0001)
    else $error("element counter did not drop by one");
  frame_dec_a: assert property (frame_last && (frame[ch] != 8'h00) && !cfg_c.autobuffering_mode
                                && !(i_chan_enable[ch] && !enable_q[ch])
                                |=> frame[$past(ch)] == $past(frame[ch]) - 8'h01)
    else $error("frame counter did not drop on frame end");
  int_off_a: assert property ((int_next & ~ie_vec) == 6'h00 ##1 (o_chan_int & ~$past(ie_vec)) == 6'h00)
    else $error("interrupt from disabled channel");
  line_map_a: assert property (($past(ils) == sdc_pkg::ILS_CH0123) |-> (o_line6 == o_chan_int[0])
                               && (o_line11 == o_chan_int[3]))
    else $error("channel interrupt misrouted");
  sel_reset_a: assert property (($past(ils) == sdc_pkg::ILS_PERIPH)
                                |-> (o_line10 == $past(i_port1_receive_interrupt)) && !o_line6)
    else $error("peripheral source not on shared line");
  dword_pair_a: assert property (first_half_s |=> (st == sdc_pkg::S_ISSUE) && half)
    else $error("second half of doubleword not issued");

endmodule

// ==== test/sdc_mem_model.sv ====
// Purpose: memory stand-in on the controller's read and write ports
// Assumes: a word read at an address is that address xor 5a5a
// Notes:   random read latency 1 to 4 cycles, random write stalls
`timescale 1ns/1ps
module sdc_mem_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // read side
  input  wire logic        i_rd_req,
  input  wire logic [15:0] i_rd_addr,
  output logic             o_rd_valid,
  output logic [15:0]      o_rd_data,
  // write side
  output logic             o_wr_ready
);
  integer seed = 32'h4806;
  int     wait_n;
  logic   answered;
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= 16'h0000;
      o_wr_ready <= 1'b0;
      wait_n     <= 0;
      answered   <= 1'b0;
    end else begin
      o_wr_ready <= ($random(seed) % 3) != 0;
      o_rd_valid <= 1'b0;
      // stale data toggles so it never passes for an answer
      o_rd_data  <= ~o_rd_data;
      if (!i_rd_req) begin
        answered <= 1'b0;
      end else if (!answered && wait_n == 0) begin
        o_rd_valid <= 1'b1;
        o_rd_data  <= i_rd_addr ^ 16'h5a5a;
        answered   <= 1'b1;
        wait_n     <= {$random(seed)} % 4;
      end else if (!answered) begin
        wait_n <= wait_n - 1;
      end
    end
  end
endmodule

// ==== test/sdc_ctrl_tb.sv ====
// Purpose: self-checking bench of the six-channel transfer controller
// Assumes: memory model answers at random pace
// Notes:   expected writes queued by the driver, popped by the monitor
`timescale 1ns/1ps
module sdc_ctrl_tb;
  logic i_clk, i_reset, rd_req, rd_valid, wr_req, wr_ready, hold;
  logic [3:0]  lines;
  logic [15:0] rd_addr, rd_data, wr_addr, wr_data;
  logic [5:0]  en, high, active, ints;
  logic [6:0]  ev, prev;
  logic [1:0]  ils;
  sdc_pkg::sdc_chan_cfg_t [5:0] cfg_a;
  sdc_pkg::sdc_chan_cfg_t       cfg;
  sdc_pkg::sdc_index_t          ix;
  logic [31:0] exp_q[$];
  logic [15:0] s, d, rs, rdst;
  sdc_pkg::sdc_reload_t         rl;
  integer seed = 32'h4806;
  int n_errors = 0, n_tests = 0, n_int, n_line, cur, t, n, per;
  sdc_ctrl dut (.i_clk(i_clk), .i_reset(i_reset), .i_cfg(cfg_a), .i_chan_enable(en), .i_chan_high(high),
    .i_reload(rl), .i_index(ix), .i_interrupt_line_select(ils), .i_port0_rx_event(ev[0]),
    .i_port0_tx_event(ev[1]), .i_port1_receive_interrupt(ev[2]), .i_port1_transmit_interrupt(ev[3]),
    .i_timer0_event(ev[4]), .i_second_timer_interrupt(ev[5]), .i_ext3_pin(ev[6]), .o_rd_req(rd_req),
    .o_rd_addr(rd_addr), .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_wr_req(wr_req), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data), .i_wr_ready(wr_ready), .o_cpu_hold(hold), .o_chan_active(active),
    .o_chan_int(ints), .o_line6(lines[0]), .o_line7(lines[1]), .o_line10(lines[2]), .o_line11(lines[3]));
  sdc_mem_model mem (.i_clk(i_clk), .i_reset(i_reset), .i_rd_req(rd_req), .i_rd_addr(rd_addr),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_wr_ready(wr_ready));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [15:0] adj(input logic [15:0] a, input logic [1:0] m, input logic last,
                                      input logic [15:0] ei, input logic [15:0] fi);
    case (m)
      sdc_pkg::ADJ_INC:   return a + 16'h0001;
      sdc_pkg::ADJ_DEC:   return a - 16'h0001;
      sdc_pkg::ADJ_INDEX: return a + (last ? fi : ei);
      default:            return a;
    endcase
  endfunction
  // monitor: every accepted write must match the oldest queued one
  always @(posedge i_clk) begin
    if (!i_reset && wr_req && wr_ready) begin
      if (exp_q.size() == 0) check({wr_addr, wr_data}, 32'hffffffff);
      else check({wr_addr, wr_data}, exp_q.pop_front());
    end
    if (!i_reset) begin
      if (wr_req) check(hold, 1'b1);
      n_int  += ints[cur];
      n_line += lines[cur];
    end
  end
  initial begin
    i_reset = 1'b1; en = '0; high = '0; ev = '0; ils = 2'h0; cfg_a = '0; cur = 0;
    ix = '{16'h0003, 16'h0005, 16'h0010, 16'h0100};
    rl = '0;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clk);
    // reset select routes peripheral sources, one cycle late
    repeat (16) begin
      @(posedge i_clk);
      prev = ev;
      ev <= 7'($random(seed));
      @(negedge i_clk);
      check(lines, {prev[3], prev[2], prev[5], 1'b0});
    end
    @(posedge i_clk);
    ev <= '0;
    ils <= 2'h2;
    // channel m: src mode m, dst mode 3-m, two frames of two elements
    // m1 autobuffers and m3 reloads, both paced by port0 receive events; m2 moves doublewords
    for (int m = 0; m < 4; m++) begin
      s = 16'($random(seed));
      d = 16'($random(seed));
      rs = 16'($random(seed));
      rdst = 16'($random(seed));
      n = (m == 0) ? 4 : 8;
      per = (m == 2) ? 4 : 2;
      cfg = '0;
      cfg.src = s; cfg.dst = d; cfg.elem_count = 16'h0001; cfg.frame_count = 8'h01;
      cfg.src_mode = m[1:0]; cfg.dst_mode = 2'h3 - m[1:0]; cfg.destination_index_select = 1'b1;
      cfg.interrupt_enable_bit = (m != 0); cfg.interrupt_mode_bit = (m >= 2);
      cfg.dword = (m == 2);
      cfg.autobuffering_mode = (m == 1);
      cfg.auto_reinit_enable = (m == 3);
      cfg.sync_event_select = m[0] ? sdc_pkg::SYNC_SP0_RX : sdc_pkg::SYNC_NONE;
      for (int k = 0; k < n; k++) begin
        if (m == 3 && k == 4) begin
          s = rs;
          d = rdst;
        end
        exp_q.push_back({d, s ^ 16'h5a5a});
        s = adj(s, m[1:0], (k % per) == per - 1, 16'h0003, 16'h0010);
        d = adj(d, 2'h3 - m[1:0], (k % per) == per - 1, 16'h0005, 16'h0100);
      end
      @(posedge i_clk);
      cur = m; n_int = 0; n_line = 0;
      cfg_a[m] <= cfg;
      en[m] <= 1'b1;
      high <= 6'($random(seed));
      // one event per element, spaced wide so none merges into one still pending
      for (t = 0; t < 2000 && (exp_q.size() != 0 || active[m] !== m[0]); t++) begin
        @(posedge i_clk);
        ev <= {6'h00, (t % 32 == 0) && (t < 256)};
        if (t == 40) rl <= '{rs, rdst, 16'h0001, 8'h01};
      end
      if (t == 2000) begin
        check(32'h0, 32'h1);
        results();
      end
      repeat (10) @(negedge i_clk);
      check(exp_q.size(), 0);
      check(n_int, (m == 0) ? 0 : (m == 2) ? 2 : 4);
      check(n_line, (m == 0) ? 0 : (m == 2) ? 2 : 4);
      check(active[m], m[0]);
      check(hold, 1'b0);
      @(posedge i_clk);
      en[m] <= 1'b0;
      ev <= '0;
    end
    repeat (4) @(posedge i_clk);
    results();
  end
endmodule
